/* File: logic/cte_core.sv */
// executor for the trap, wait, zero-test and transfer instructions
// assumes memory read data is valid in the cycle the address is shown
`timescale 1ns/10ps
`default_nettype none
module cte_core (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // memory bus
  output logic [15:0] mem_addr,
  output logic mem_re,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // interrupt and wait status
  input wire logic irq_req,
  output logic wait_halt,
  // architectural state
  output logic [7:0] acc,
  output logic [15:0] index,
  output logic [15:0] stackptr,
  output logic [7:0] flags,
  output logic [15:0] progctr
);
  cte_pkg::cte_state_t st_q, st_d;
  logic [15:0] pc_q, pc_d, hx_q, hx_d, sp_q, sp_d, vec_q, vec_d;
  logic [7:0] a_q, a_d, fl_q, fl_d, op_q, op_d, b1_q, b1_d, b2_q, b2_d;
  logic [7:0] md_q, md_d;
  logic pre_q, pre_d;
  logic [2:0] cnt_q, cnt_d;
  logic [15:0] ea;

  wire [7:0] rd = mem_rdata;
  wire [15:0] pc_inc = pc_q + 16'h0001;
  wire [15:0] rel_tgt = pc_inc + {{8{rd[7]}}, rd};
  wire cte_pkg::cte_mode_t cur_mode = cte_pkg::mode_of(op_q, pre_q);
  wire cte_pkg::cte_mode_t new_mode = cte_pkg::mode_of(rd, 1'b0);
  wire is_cbeq = (op_q == cte_pkg::OP_CBEQ_DIR) ||
                 (op_q == cte_pkg::OP_CBEQ_IXP);
  wire two_byte = (cur_mode == cte_pkg::MD_FULL) ||
                  (cur_mode == cte_pkg::MD_IXW);
  wire fetching = (st_q == cte_pkg::ST_FETCH);

  cte_ea_gen u_ea (
    .mode(cur_mode),
    .byte1(b1_q),
    .byte2(b2_q),
    .index(hx_q),
    .stackptr(sp_q),
    .ea(ea)
  );

  // bus drive: one access per cycle
  always_comb begin
    mem_addr = pc_q;
    mem_re = 1'b1;
    mem_we = 1'b0;
    mem_wdata = 8'h00;
    unique case (st_q)
      cte_pkg::ST_READ: mem_addr = ea;
      cte_pkg::ST_PUSH: begin
        mem_addr = sp_q;
        mem_re = 1'b0;
        mem_we = 1'b1;
        unique case (cnt_q)
          3'h0: mem_wdata = pc_q[7:0];
          3'h1: mem_wdata = pc_q[15:8];
          3'h2: mem_wdata = hx_q[7:0];
          3'h3: mem_wdata = a_q;
          default: mem_wdata = fl_q;
        endcase
      end
      cte_pkg::ST_VECH: mem_addr = vec_q;
      cte_pkg::ST_VECL: mem_addr = vec_q + 16'h0001;
      cte_pkg::ST_INH, cte_pkg::ST_TRAP, cte_pkg::ST_WAIT: mem_re = 1'b0;
      default: mem_addr = pc_q;
    endcase
  end

  // sequencing and execution
  always_comb begin
    st_d = st_q;
    pc_d = pc_q;
    hx_d = hx_q;
    sp_d = sp_q;
    vec_d = vec_q;
    a_d = a_q;
    fl_d = fl_q;
    op_d = op_q;
    b1_d = b1_q;
    b2_d = b2_q;
    md_d = md_q;
    pre_d = pre_q;
    cnt_d = cnt_q;
    unique case (st_q)
      cte_pkg::ST_FETCH: begin
        pc_d = pc_inc;
        op_d = rd;
        pre_d = 1'b0;
        cnt_d = 3'h0;
        st_d = cte_pkg::ST_FETCH;
        case (rd)
          cte_pkg::OP_PREFIX: st_d = cte_pkg::ST_PRE;
          cte_pkg::OP_ZT_ACC: fl_d = cte_pkg::zt_flags(fl_q, a_q);
          cte_pkg::OP_ZT_IDX: fl_d = cte_pkg::zt_flags(fl_q, hx_q[7:0]);
          cte_pkg::OP_ACC_TO_IDX: hx_d[7:0] = a_q;
          cte_pkg::OP_IDX_TO_ACC: a_d = hx_q[7:0];
          cte_pkg::OP_FL_TO_ACC: a_d = fl_q;
          cte_pkg::OP_TAP, cte_pkg::OP_SP_TO_IDX, cte_pkg::OP_IDX_TO_SP:
            st_d = cte_pkg::ST_INH;
          cte_pkg::OP_TRAP: begin
            vec_d = cte_pkg::VEC_TRAP;
            st_d = cte_pkg::ST_TRAP;
          end
          cte_pkg::OP_WAIT: begin
            fl_d[cte_pkg::FL_I] = 1'b0;
            st_d = cte_pkg::ST_WAIT;
          end
          default: begin
            if (new_mode == cte_pkg::MD_IX || new_mode == cte_pkg::MD_IXP)
              st_d = cte_pkg::ST_READ;
            else if (new_mode != cte_pkg::MD_NONE)
              st_d = cte_pkg::ST_OP1;
          end
        endcase
      end
      cte_pkg::ST_PRE: begin
        pc_d = pc_inc;
        op_d = rd;
        pre_d = 1'b1;
        st_d = (rd == cte_pkg::OP_ZT_SPS) ? cte_pkg::ST_OP1 :
               cte_pkg::ST_FETCH;
      end
      cte_pkg::ST_OP1: begin
        pc_d = pc_inc;
        b1_d = rd;
        st_d = two_byte ? cte_pkg::ST_OP2 : cte_pkg::ST_READ;
      end
      cte_pkg::ST_OP2: begin
        pc_d = pc_inc;
        b2_d = rd;
        st_d = cte_pkg::ST_READ;
      end
      cte_pkg::ST_READ: begin
        md_d = rd;
        st_d = cte_pkg::ST_FETCH;
        if (is_cbeq) begin
          if (cur_mode == cte_pkg::MD_IXP) hx_d = hx_q + 16'h0001;
          st_d = cte_pkg::ST_REL;
        end else begin
          if (!pre_q && op_q[7]) a_d = rd;
          fl_d = cte_pkg::zt_flags(fl_q, rd);
        end
      end
      cte_pkg::ST_REL: begin
        pc_d = (a_q == md_q) ? rel_tgt : pc_inc;
        st_d = cte_pkg::ST_FETCH;
      end
      cte_pkg::ST_INH: begin
        st_d = cte_pkg::ST_FETCH;
        case (op_q)
          cte_pkg::OP_TAP: fl_d = a_q | cte_pkg::FL_ONES;
          cte_pkg::OP_SP_TO_IDX: hx_d = sp_q + 16'h0001;
          default: sp_d = hx_q - 16'h0001;
        endcase
      end
      cte_pkg::ST_TRAP: st_d = cte_pkg::ST_PUSH;
      cte_pkg::ST_PUSH: begin
        sp_d = sp_q - 16'h0001;
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == cte_pkg::PUSH_LAST) begin
          fl_d[cte_pkg::FL_I] = 1'b1;
          st_d = cte_pkg::ST_VECH;
        end
      end
      cte_pkg::ST_VECH: begin
        b1_d = rd;
        st_d = cte_pkg::ST_VECL;
      end
      cte_pkg::ST_VECL: begin
        pc_d = {b1_q, rd};
        st_d = cte_pkg::ST_FETCH;
      end
      cte_pkg::ST_WAIT: begin
        if (irq_req) begin
          vec_d = cte_pkg::VEC_IRQ;
          cnt_d = 3'h0;
          st_d = cte_pkg::ST_PUSH;
        end
      end
      default: st_d = cte_pkg::ST_FETCH;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= cte_pkg::ST_VECH;
      vec_q <= cte_pkg::VEC_RESET;
      pc_q <= cte_pkg::RST_PC;
      sp_q <= cte_pkg::RST_SP;
      fl_q <= cte_pkg::RST_FLAGS;
      {hx_q, a_q, op_q, b1_q, b2_q, md_q} <= '0;
      {pre_q, cnt_q} <= '0;
    end else begin
      st_q <= st_d;
      vec_q <= vec_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      fl_q <= fl_d;
      {hx_q, a_q, op_q, b1_q, b2_q, md_q} <=
        {hx_d, a_d, op_d, b1_d, b2_d, md_d};
      {pre_q, cnt_q} <= {pre_d, cnt_d};
    end
  end

  assign wait_halt = (st_q == cte_pkg::ST_WAIT);
  assign acc = a_q;
  assign index = hx_q;
  assign stackptr = sp_q;
  assign flags = fl_q;
  assign progctr = pc_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_op(logic [7:0] code);
    fetching && rd == code;
  endsequence
  sequence s_trap_tail;
    (st_q == cte_pkg::ST_PUSH) [*5] ##1 (st_q == cte_pkg::ST_VECH)
      ##1 (st_q == cte_pkg::ST_VECL) ##1 fetching;
  endsequence

  chk_trap_timing: assert property (s_op(cte_pkg::OP_TRAP) |=>
    (st_q == cte_pkg::ST_TRAP) ##1 s_trap_tail)
    else $error("trap sequence not nine cycles");
  chk_trap_stack: assert property (s_op(cte_pkg::OP_TRAP) |->
    ##2 (mem_we && mem_wdata == $past(pc_inc[7:0], 2)) ##5
    (sp_q == $past(sp_q, 7) - 16'h0005 && fl_q[cte_pkg::FL_I]))
    else $error("trap pushes or mask wrong");
  chk_wait_mask: assert property (s_op(cte_pkg::OP_WAIT) |=>
    wait_halt && !fl_q[cte_pkg::FL_I])
    else $error("wait did not clear mask and halt");
  chk_test_flags: assert property (s_op(cte_pkg::OP_ZT_ACC) |=>
    !fl_q[cte_pkg::FL_V] && fl_q[cte_pkg::FL_N] == a_q[7] &&
    fl_q[cte_pkg::FL_Z] == (a_q == 8'h00) &&
    $stable({fl_q[cte_pkg::FL_H:cte_pkg::FL_I], fl_q[cte_pkg::FL_C]}))
    else $error("zero test flags wrong");
  chk_test_cycles: assert property (s_op(cte_pkg::OP_ZT_DIR) |=>
    !fetching [*2] ##1 fetching)
    else $error("direct zero test not three cycles");
  chk_wide_addr: assert property (st_q == cte_pkg::ST_READ &&
    cur_mode == cte_pkg::MD_IXW |-> mem_addr == hx_q + {b1_q, b2_q})
    else $error("wide indexed address wrong");
  chk_short_addr: assert property (st_q == cte_pkg::ST_READ &&
    cur_mode == cte_pkg::MD_IXS |-> mem_addr == hx_q + {8'h00, b1_q})
    else $error("short indexed address wrong");
  chk_full_addr: assert property (st_q == cte_pkg::ST_OP2 &&
    cur_mode == cte_pkg::MD_FULL |=> mem_addr == {$past(b1_q), $past(rd)})
    else $error("full address wrong");
  chk_branch_rel: assert property (st_q == cte_pkg::ST_REL &&
    a_q == md_q |=> pc_q == $past(rel_tgt))
    else $error("branch displacement wrong");
  chk_post_inc: assert property (st_q == cte_pkg::ST_READ &&
    cur_mode == cte_pkg::MD_IXP |-> mem_addr == hx_q ##1
    hx_q == $past(hx_q) + 16'h0001)
    else $error("post increment wrong");
  chk_stack_xfer: assert property (s_op(cte_pkg::OP_SP_TO_IDX) |->
    ##2 (fetching && hx_q == sp_q + 16'h0001 && $stable(fl_q)))
    else $error("stack to index transfer wrong");
  chk_flag_load: assert property (s_op(cte_pkg::OP_TAP) |->
    ##2 (fl_q == ($past(a_q, 2) | cte_pkg::FL_ONES)))
    else $error("accumulator to flags wrong");
endmodule
`default_nettype wire

/* File: logic/cte_ea_gen.sv */
// effective address generator for the operand addressing modes
// assumes operand bytes are already captured by the caller
`timescale 1ns/10ps
`default_nettype none
module cte_ea_gen (
  // mode and operand bytes
  input wire cte_pkg::cte_mode_t mode,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  // base registers
  input wire logic [15:0] index,
  input wire logic [15:0] stackptr,
  // result
  output logic [15:0] ea
);
  wire [15:0] short_off = {8'h00, byte1};
  wire [15:0] wide_off = {byte1, byte2};

  always_comb begin
    unique case (mode)
      cte_pkg::MD_DIR: ea = short_off;
      cte_pkg::MD_FULL: ea = wide_off;
      cte_pkg::MD_IXS: ea = index + short_off;
      cte_pkg::MD_IXW: ea = index + wide_off;
      cte_pkg::MD_SP1: ea = stackptr + short_off;
      default: ea = index;
    endcase
  end
endmodule
`default_nettype wire

/* File: logic/cte_pkg.sv */
// constants, opcodes, states and decode helpers for the cpu tail executor
// assumes a byte-wide memory bus with combinational read data
package cte_pkg;
  // opcodes handled by the executor
  localparam logic [7:0] OP_TRAP = 8'h83;
  localparam logic [7:0] OP_TAP = 8'h84;
  localparam logic [7:0] OP_FL_TO_ACC = 8'h85;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [7:0] OP_ACC_TO_IDX = 8'h97;
  localparam logic [7:0] OP_IDX_TO_ACC = 8'h9f;
  localparam logic [7:0] OP_SP_TO_IDX = 8'h95;
  localparam logic [7:0] OP_IDX_TO_SP = 8'h94;
  localparam logic [7:0] OP_ZT_DIR = 8'h3d;
  localparam logic [7:0] OP_ZT_ACC = 8'h4d;
  localparam logic [7:0] OP_ZT_IDX = 8'h5d;
  localparam logic [7:0] OP_ZT_IXS = 8'h6d;
  localparam logic [7:0] OP_ZT_IX = 8'h7d;
  localparam logic [7:0] OP_PREFIX = 8'h9e;
  localparam logic [7:0] OP_ZT_SPS = 8'h6d;
  localparam logic [7:0] OP_LOAD_FULL = 8'hc6;
  localparam logic [7:0] OP_LOAD_IXW = 8'hd6;
  localparam logic [7:0] OP_LOAD_IXS = 8'he6;
  localparam logic [7:0] OP_CBEQ_DIR = 8'h31;
  localparam logic [7:0] OP_CBEQ_IXP = 8'h71;
  // flags register bit positions; bits 6 and 5 always read one
  localparam int FL_V = 7;
  localparam int FL_H = 4;
  localparam int FL_I = 3;
  localparam int FL_N = 2;
  localparam int FL_Z = 1;
  localparam int FL_C = 0;
  localparam logic [7:0] FL_ONES = 8'h60;
  // reset values
  localparam logic [7:0] RST_FLAGS = 8'h68;
  localparam logic [15:0] RST_SP = 16'h00ff;
  localparam logic [15:0] RST_PC = 16'h0000;
  // vector addresses (high byte at the address, low byte at +1)
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_IRQ = 16'hfffa;
  localparam logic [2:0] PUSH_LAST = 3'h4;

  typedef enum logic [3:0] {
    ST_FETCH = 4'h0, ST_PRE = 4'h1, ST_OP1 = 4'h2, ST_OP2 = 4'h3,
    ST_READ = 4'h4, ST_REL = 4'h5, ST_INH = 4'h6, ST_TRAP = 4'h7,
    ST_PUSH = 4'h8, ST_VECH = 4'h9, ST_VECL = 4'ha, ST_WAIT = 4'hb
  } cte_state_t;

  typedef enum logic [2:0] {
    MD_NONE = 3'h0, MD_DIR = 3'h1, MD_FULL = 3'h2, MD_IX = 3'h3,
    MD_IXS = 3'h4, MD_IXW = 3'h5, MD_SP1 = 3'h6, MD_IXP = 3'h7
  } cte_mode_t;

  // addressing mode of a memory-operand opcode
  function automatic cte_mode_t mode_of(input logic [7:0] op,
                                        input logic pre);
    mode_of = MD_NONE;
    if (pre) begin
      if (op == OP_ZT_SPS) mode_of = MD_SP1;
    end else begin
      case (op)
        OP_ZT_DIR, OP_CBEQ_DIR: mode_of = MD_DIR;
        OP_ZT_IXS, OP_LOAD_IXS: mode_of = MD_IXS;
        OP_ZT_IX: mode_of = MD_IX;
        OP_LOAD_FULL: mode_of = MD_FULL;
        OP_LOAD_IXW: mode_of = MD_IXW;
        OP_CBEQ_IXP: mode_of = MD_IXP;
        default: mode_of = MD_NONE;
      endcase
    end
  endfunction

  // flags after a zero test or load of val
  function automatic logic [7:0] zt_flags(input logic [7:0] fl,
                                          input logic [7:0] val);
    zt_flags = fl;
    zt_flags[FL_V] = 1'b0;
    zt_flags[FL_N] = val[7];
    zt_flags[FL_Z] = (val == 8'h00);
  endfunction
endpackage

/* File: sim/cte_core_tb.sv */
// self-checking bench for the cpu tail executor
// assumes the core reads reset vector fffe/ffff, trap fffc, wake fffa
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module cte_core_tb;
  typedef struct {
    logic [63:0] code;
    int n;
    logic [7:0] a;
    logic [7:0] f;
    logic [15:0] x;
    logic [15:0] sp;
    logic [15:0] pc;
  } cte_row_t;
  logic mclk, reset, irq_req, mem_re, mem_we, wait_halt;
  logic [15:0] mem_addr, index, stackptr, progctr;
  logic [7:0] mem_wdata, mem_rdata, acc, flags;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int w;
  // every program starts: load a from 0080 (91), copy a into flags
  cte_row_t rows [14] = '{
    '{64'hc6008084_4d000000, 7, 8'h91, 8'h75, 16'h0000, 16'h00ff, 16'h0105},
    '{64'hc6008084_5d000000, 7, 8'h91, 8'h73, 16'h0000, 16'h00ff, 16'h0105},
    '{64'hc6008084_3d800000, 9, 8'h91, 8'h75, 16'h0000, 16'h00ff, 16'h0106},
    '{64'hc6008084_7d000000, 8, 8'h91, 8'h73, 16'h0000, 16'h00ff, 16'h0105},
    '{64'hc6008084_6d800000, 9, 8'h91, 8'h75, 16'h0000, 16'h00ff, 16'h0106},
    '{64'hc6008084_9e6d8100, 10, 8'h91, 8'h73, 16'h0000, 16'h00ff, 16'h0107},
    '{64'hc6008084_97000000, 7, 8'h91, 8'hf1, 16'h0091, 16'h00ff, 16'h0105},
    '{64'hc6008084_85000000, 7, 8'hf1, 8'hf1, 16'h0000, 16'h00ff, 16'h0105},
    '{64'hc6008084_95000000, 8, 8'h91, 8'hf1, 16'h0100, 16'h00ff, 16'h0105},
    '{64'hc6008084_94000000, 8, 8'h91, 8'hf1, 16'h0000, 16'hffff, 16'h0105},
    '{64'hc6008084_9f000000, 7, 8'h00, 8'hf1, 16'h0000, 16'h00ff, 16'h0105},
    '{64'hc6008084_d6010000, 10, 8'hc6, 8'h75, 16'h0000, 16'h00ff, 16'h0107},
    '{64'hc6008084_3180fd00, 10, 8'h91, 8'hf1, 16'h0000, 16'h00ff, 16'h0104},
    '{64'hc6008084_97710500, 10, 8'h91, 8'hf1, 16'h0092, 16'h00ff, 16'h010c}
  };
  // stack bytes after trap: pc low, pc high, x, a, flags
  logic [7:0] stk [5] = '{8'h05, 8'h01, 8'h00, 8'h91, 8'hf1};

  cte_core i_cte_core (
    .mclk(mclk), .reset(reset), .mem_addr(mem_addr), .mem_re(mem_re),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .irq_req(irq_req), .wait_halt(wait_halt), .acc(acc), .index(index),
    .stackptr(stackptr), .flags(flags), .progctr(progctr)
  );
  cte_mem i_cte_mem (
    .mclk(mclk), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      results();
    end
  end

  // reset, load code at 0100, run n cycles past the vector fetch
  task automatic run(input logic [63:0] code, input int n);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      i_cte_mem.mem[16'h0100 + i] = code[63 - 8 * i -: 8];
    end
    reset <= 1'b0;
    repeat (2 + n) @(posedge mclk);
    @(negedge mclk);
  endtask

  initial begin
    reset = 1'b1;
    irq_req = 1'b0;
    for (int i = 0; i < 65536; i++) i_cte_mem.mem[i] = 8'ha5;
    i_cte_mem.mem[16'hfffe] = 8'h01;
    i_cte_mem.mem[16'hffff] = 8'h00;
    i_cte_mem.mem[16'hfffc] = 8'h02;
    i_cte_mem.mem[16'hfffd] = 8'h00;
    i_cte_mem.mem[16'hfffa] = 8'h03;
    i_cte_mem.mem[16'hfffb] = 8'h00;
    i_cte_mem.mem[16'h0080] = 8'h91;
    i_cte_mem.mem[16'h0091] = 8'h91;
    i_cte_mem.mem[16'h0000] = 8'h00;
    i_cte_mem.mem[16'h0180] = 8'h00;
    i_cte_mem.mem[16'hff80] = 8'h00;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK(mem_addr, 16'hfffe)
    `CHK(flags, 8'h68)
    `CHK(stackptr, 16'h00ff)
    $display("reset test done");
    foreach (rows[k]) begin
      run(rows[k].code, rows[k].n);
      `CHK(acc, rows[k].a)
      `CHK(flags, rows[k].f)
      `CHK(index, rows[k].x)
      `CHK(stackptr, rows[k].sp)
      `CHK(mem_addr, rows[k].pc)
      `CHK(progctr, rows[k].pc)
      $display("row %0d done", k);
    end
    // trap: five pushes, mask set, vector fetch after nine cycles
    run(64'hc6008084_83000000, 15);
    `CHK(mem_addr, 16'h0200)
    `CHK(flags, 8'hf9)
    `CHK(stackptr, 16'h00fa)
    for (int i = 0; i < 5; i++) begin
      `CHK(i_cte_mem.mem[16'h00ff - i], stk[i])
    end
    $display("trap test done");
    // wait: mask cleared, bus quiet until the interrupt wakes it
    run(64'hc600808f_00000000, 5);
    `CHK(wait_halt, 1'b1)
    `CHK(flags, 8'h64)
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    `CHK(wait_halt, 1'b1)
    `CHK(mem_re, 1'b0)
    @(posedge mclk);
    irq_req <= 1'b1;
    w = 0;
    while (!(mem_re === 1'b1 && mem_addr === 16'h0300) && w < 20) begin
      @(negedge mclk);
      w++;
    end
    `CHK(mem_addr, 16'h0300)
    `CHK(i_cte_mem.mem[16'h00fb], 8'h64)
    @(posedge mclk);
    irq_req <= 1'b0;
    $display("wait test done");
    results();
  end
endmodule
`default_nettype wire

/* File: sim/cte_mem.sv */
// behavioural program and data memory on the cpu bus
// assumes one access per cycle: reads combinational, writes at the edge
`timescale 1ns/10ps
`default_nettype none
module cte_mem (
  // clock
  input wire logic mclk,
  // bus from the core
  input wire logic [15:0] mem_addr,
  input wire logic mem_re,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output var logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  // an idle bus shows the inverse of the last read, never a stale copy
  assign mem_rdata = mem_re ? mem[mem_addr] : ~last_q;
  initial last_q = 8'h00;
  always @(posedge mclk) begin
    if (mem_re) last_q <= mem[mem_addr];
    if (mem_we) mem[mem_addr] <= mem_wdata;
  end
endmodule
`default_nettype wire
